//--- hdl/msc_host_end.sv
`timescale 1ns/10ps
`include "msc_cfg.svh"
module msc_host_end import msc_pkg::*; #(
	parameter int unsigned HOLD_CYCLES = `MSC_HOST_HOLD_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	msc_sideband_if.host_mp link,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic irq,
	input wire logic tw_scl_out,
	input wire logic tw_sda_low,
	output logic tw_sda_in
);
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic [2:0] pin_s3;
	logic [2:0] pin_f;
	logic [2:0] pin_prev;
	logic [1:0] ctrl;
	logic [31:0] hold_cnt;
	logic busy;
	logic waiting;
	logic [7:0] status;
	logic [7:0] mask;
	logic [7:0] set_bits;
	logic [7:0] clr_bits;
	logic start;
	logic attn_fall;

	assign start = reg_wr && reg_addr == `MSC_HOST_CTRL && reg_wdata[`MSC_HOST_RESTART] && !busy;
	assign attn_fall = pin_prev[0] && !pin_f[0];

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pin_s1 <= `MSC_HOST_PIN_RST;
			pin_s2 <= `MSC_HOST_PIN_RST;
			pin_s3 <= `MSC_HOST_PIN_RST;
			pin_f <= `MSC_HOST_PIN_RST;
			pin_prev <= `MSC_HOST_PIN_RST;
		end else begin
			pin_s1 <= {link.sda, link.presence_seen_n, link.attention_n};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f <= (pin_s3 & ~(pin_s2 ^ pin_s3)) | (pin_f & (pin_s2 ^ pin_s3));
			pin_prev <= pin_f;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			ctrl <= 2'h0;
		else if (reg_wr && reg_addr == `MSC_HOST_CTRL)
			ctrl <= reg_wdata[1:0];
	end

	// restart pulse held long enough to count as a full reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			busy <= 1'b0;
			hold_cnt <= 32'h0;
		end else if (start) begin
			busy <= 1'b1;
			hold_cnt <= 32'h0;
		end else if (busy) begin
			if (hold_cnt >= HOLD_CYCLES - 1)
				busy <= 1'b0;
			hold_cnt <= hold_cnt + 32'h1;
		end
	end

	// module status is not trusted until attention after a restart
	always_ff @(posedge mclk) begin
		if (!rst_n)
			waiting <= 1'b1;
		else if (start)
			waiting <= 1'b1;
		else if (!busy && attn_fall)
			waiting <= 1'b0;
	end

	always_comb begin
		set_bits = 8'h00;
		set_bits[`MSC_HOST_ATTN] = attn_fall;
		set_bits[`MSC_HOST_PRES] = pin_prev[1] ^ pin_f[1];
		set_bits[`MSC_HOST_READY] = waiting && !busy && attn_fall;
		clr_bits = (reg_wr && reg_addr == `MSC_HOST_STATUS) ? reg_wdata : 8'h00;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			status <= 8'h00;
			mask <= `MSC_HOST_MASK_RST;
			irq <= 1'b0;
		end else begin
			status <= msc_w1c(status, set_bits, clr_bits) & `MSC_HOST_MASK_RST;
			if (reg_wr && reg_addr == `MSC_HOST_MASK)
				mask <= reg_wdata & `MSC_HOST_MASK_RST;
			irq <= |(status & mask);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			link.sel_oe <= 1'b0;
			link.restart_oe <= 1'b0;
			link.lp_out <= 1'b0;
			link.scl_out <= 1'b1;
			link.sda_host_oe <= 1'b0;
			tw_sda_in <= 1'b1;
		end else begin
			link.sel_oe <= ctrl[`MSC_HOST_SELECT];
			link.restart_oe <= start | (busy && hold_cnt < HOLD_CYCLES - 1);
			link.lp_out <= ctrl[`MSC_HOST_LOWPWR];
			link.scl_out <= tw_scl_out;
			link.sda_host_oe <= tw_sda_low;
			tw_sda_in <= pin_f[2];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
			`MSC_HOST_CTRL: reg_rdata <= {5'h0, busy, ctrl};
			`MSC_HOST_STATUS: reg_rdata <= status;
			`MSC_HOST_MASK: reg_rdata <= mask;
			`MSC_HOST_LINE: reg_rdata <= {4'h0, waiting, busy, pin_f[1], pin_f[0]};
			default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule : msc_host_end

//--- hdl/msc_module_end.sv
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "msc_cfg.svh"
module msc_module_end import msc_pkg::*; #(
	parameter int unsigned RESTART_MIN_CYCLES = `MSC_RESTART_MIN_CYCLES,
	parameter int unsigned INIT_CYCLES = `MSC_INIT_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	msc_sideband_if.dev_mp link,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic fault_event,
	input wire logic critical_event,
	input wire logic tw_drive_low,
	output logic tw_scl,
	output logic tw_sda,
	output logic tw_selected,
	output logic low_power,
	output logic settings_restore,
	output logic data_not_ready,
	output logic irq
);
	logic [4:0] pin_s1;
	logic [4:0] pin_s2;
	logic [4:0] pin_s3;
	logic [4:0] pin_f;
	logic [4:0] pins;
	msc_dev_state_t state;
	logic [31:0] cnt;
	logic [7:0] status;
	logic [7:0] mask;
	logic [7:0] set_bits;
	logic [7:0] clr_bits;
	logic sel;
	logic restart_f;
	logic init_finish;
	logic restart_taken;

	assign pins = {link.sda, link.scl, link.low_power_request, link.module_restart_n, link.bus_select_n};
	assign sel = ~pin_f[0];
	assign restart_f = pin_f[1];
	assign init_finish = (state == MSC_ST_INIT) && restart_f && (cnt >= INIT_CYCLES - 1);
	assign restart_taken = (state == MSC_ST_HELD) && restart_f && (cnt >= RESTART_MIN_CYCLES);

	// a change counts only once stages two and three agree
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pin_s1 <= `MSC_DEV_PIN_RST;
			pin_s2 <= `MSC_DEV_PIN_RST;
			pin_s3 <= `MSC_DEV_PIN_RST;
			pin_f <= `MSC_DEV_PIN_RST;
		end else begin
			pin_s1 <= pins;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f <= (pin_s3 & ~(pin_s2 ^ pin_s3)) | (pin_f & (pin_s2 ^ pin_s3));
		end
	end

	// power-up starts in the init interval, so completion is posted unprompted
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state <= MSC_ST_INIT;
			cnt <= 32'h0;
		end else begin
			case (state)
			MSC_ST_INIT: begin
				if (!restart_f) begin
					state <= MSC_ST_HELD;
					cnt <= 32'h1;
				end else if (init_finish) begin
					state <= MSC_ST_RUN;
					cnt <= 32'h0;
				end else begin
					cnt <= cnt + 32'h1;
				end
			end
			MSC_ST_RUN: begin
				if (!restart_f) begin
					state <= MSC_ST_HELD;
					cnt <= 32'h1;
				end
			end
			MSC_ST_HELD: begin
				if (restart_taken) begin
					state <= MSC_ST_INIT;
					cnt <= 32'h0;
				end else if (restart_f) begin
					// glitch shorter than the minimum pulse: no reset
					state <= MSC_ST_RUN;
					cnt <= 32'h0;
				end else if (cnt != 32'hffffffff) begin
					cnt <= cnt + 32'h1;
				end
			end
			default: begin
				state <= MSC_ST_INIT;
				cnt <= 32'h0;
			end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			settings_restore <= 1'b0;
			data_not_ready <= 1'b1;
		end else begin
			settings_restore <= restart_taken;
			if (restart_taken)
				data_not_ready <= 1'b1;
			else if (init_finish)
				data_not_ready <= 1'b0;
		end
	end

	always_comb begin
		set_bits = 8'h00;
		set_bits[`MSC_DEV_INIT_DONE] = init_finish;
		set_bits[`MSC_DEV_FAULT] = fault_event;
		set_bits[`MSC_DEV_CRIT] = critical_event;
		clr_bits = (reg_wr && reg_addr == `MSC_DEV_STATUS) ? reg_wdata : 8'h00;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			status <= 8'h00;
			mask <= `MSC_DEV_MASK_RST;
		end else begin
			status <= msc_w1c(status, set_bits, clr_bits) & `MSC_DEV_MASK_RST;
			// a full restart wins over a mask write in the same cycle
			if (restart_taken)
				mask <= `MSC_DEV_MASK_RST;
			else if (reg_wr && reg_addr == `MSC_DEV_MASK)
				mask <= reg_wdata & `MSC_DEV_MASK_RST;
		end
	end

	// attention only ever pulls the line low
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			link.attention_oe <= 1'b0;
			irq <= 1'b0;
			link.presence_n <= 1'b0;
		end else begin
			link.attention_oe <= |(status & mask);
			irq <= |(status & mask);
			link.presence_n <= 1'b0;
		end
	end

	// deselected: bus seen idle inside, data line never driven
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tw_scl <= 1'b1;
			tw_sda <= 1'b1;
			tw_selected <= 1'b0;
			link.sda_dev_oe <= 1'b0;
			low_power <= 1'b0;
		end else begin
			tw_scl <= sel ? pin_f[3] : 1'b1;
			tw_sda <= sel ? pin_f[4] : 1'b1;
			tw_selected <= sel;
			link.sda_dev_oe <= sel & tw_drive_low;
			low_power <= pin_f[2];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
			`MSC_DEV_STATUS: reg_rdata <= status;
			`MSC_DEV_MASK: reg_rdata <= mask;
			`MSC_DEV_STATE: reg_rdata <= {3'h0, state, sel, pin_f[2], data_not_ready};
			default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule : msc_module_end

//--- include/msc_cfg.svh
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH

`define MSC_CLK_NS 10
`define MSC_RESTART_MIN_NS 10000
`define MSC_RESTART_MIN_CYCLES ((`MSC_RESTART_MIN_NS + `MSC_CLK_NS - 1) / `MSC_CLK_NS)
`define MSC_INIT_NS 2000000
`define MSC_INIT_CYCLES (`MSC_INIT_NS / `MSC_CLK_NS)
`define MSC_HOST_HOLD_NS 20000
`define MSC_HOST_HOLD_CYCLES ((`MSC_HOST_HOLD_NS + `MSC_CLK_NS - 1) / `MSC_CLK_NS)

// module end registers
`define MSC_DEV_STATUS 2'h0
`define MSC_DEV_MASK 2'h1
`define MSC_DEV_STATE 2'h2
`define MSC_DEV_INIT_DONE 0
`define MSC_DEV_FAULT 1
`define MSC_DEV_CRIT 2
`define MSC_DEV_MASK_RST 8'h07
`define MSC_DEV_PIN_RST 5'h1b

// host end registers
`define MSC_HOST_CTRL 2'h0
`define MSC_HOST_STATUS 2'h1
`define MSC_HOST_MASK 2'h2
`define MSC_HOST_LINE 2'h3
`define MSC_HOST_SELECT 0
`define MSC_HOST_LOWPWR 1
`define MSC_HOST_RESTART 2
`define MSC_HOST_ATTN 0
`define MSC_HOST_PRES 1
`define MSC_HOST_READY 2
`define MSC_HOST_MASK_RST 8'h07
`define MSC_HOST_PIN_RST 3'h7
`endif

//--- include/msc_pkg.sv
package msc_pkg;
	typedef enum logic [1:0] {
		MSC_ST_INIT = 2'b00,
		MSC_ST_RUN = 2'b01,
		MSC_ST_HELD = 2'b11
	} msc_dev_state_t;

	// set wins over a simultaneous clear
	function automatic logic [7:0] msc_w1c(input logic [7:0] cur, input logic [7:0] set, input logic [7:0] clr);
		return (cur & ~clr) | set;
	endfunction : msc_w1c
endpackage : msc_pkg

//--- include/msc_sideband_if.sv
`timescale 1ns/10ps
interface msc_sideband_if (
	input logic module_inserted
);
	logic sel_oe;
	logic restart_oe;
	logic lp_out;
	logic scl_out;
	logic sda_host_oe;
	logic presence_n;
	logic attention_oe;
	logic sda_dev_oe;
	logic bus_select_n;
	logic module_restart_n;
	logic low_power_request;
	logic presence_seen_n;
	logic attention_n;
	logic scl;
	logic sda;

	assign bus_select_n = ~sel_oe;
	assign module_restart_n = ~restart_oe;
	assign low_power_request = lp_out;
	assign presence_seen_n = module_inserted ? presence_n : 1'b1;
	assign attention_n = ~(module_inserted & attention_oe);
	assign scl = scl_out;
	assign sda = ~(sda_host_oe | (module_inserted & sda_dev_oe));

	modport dev_mp (
		input bus_select_n,
		input module_restart_n,
		input low_power_request,
		input scl,
		input sda,
		output presence_n,
		output attention_oe,
		output sda_dev_oe
	);
	modport host_mp (
		output sel_oe,
		output restart_oe,
		output lp_out,
		output scl_out,
		output sda_host_oe,
		input presence_seen_n,
		input attention_n,
		input sda
	);
endinterface : msc_sideband_if

//--- testbench/module_sideband_control_tb.sv
`timescale 1ns/10ps
`include "msc_cfg.svh"
module module_sideband_control_tb;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic ins = 1'b1;
	logic [1:0] a = 2'h0;
	logic [7:0] wd = 8'h00;
	logic d_wr = 1'b0, d_rd = 1'b0, h_wr = 1'b0, h_rd = 1'b0;
	logic flt = 1'b0, crit = 1'b0, drv = 1'b0;
	logic h_scl = 1'b1, h_sda = 1'b0;
	logic tscl, h_sdi;
	logic [7:0] d_q, h_q;
	logic d_irq, h_irq, dnr, lp, sel, rest, tws;
	int fail_count = 0;
	int n_tests = 0;
	int cyc = 0;
	int n;
	msc_sideband_if i_link (.module_inserted(ins));
	msc_module_end #(.RESTART_MIN_CYCLES(8), .INIT_CYCLES(20)) i_msc_module_end (.mclk(mclk), .rst_n(rst_n),
		.link(i_link.dev_mp), .reg_addr(a), .reg_wdata(wd), .reg_wr(d_wr), .reg_rd(d_rd), .reg_rdata(d_q),
		.fault_event(flt), .critical_event(crit), .tw_drive_low(drv), .tw_scl(tscl), .tw_sda(tws), .tw_selected(sel),
		.low_power(lp), .settings_restore(rest), .data_not_ready(dnr), .irq(d_irq));
	msc_host_end #(.HOLD_CYCLES(16)) i_msc_host_end (.mclk(mclk), .rst_n(rst_n), .link(i_link.host_mp),
		.reg_addr(a), .reg_wdata(wd), .reg_wr(h_wr), .reg_rd(h_rd), .reg_rdata(h_q), .irq(h_irq),
		.tw_scl_out(h_scl), .tw_sda_low(h_sda), .tw_sda_in(h_sdi));
	msc_sideband_props i_props (.mclk(mclk), .rst_n(rst_n), .module_inserted(ins), .sel_oe(i_link.sel_oe),
		.restart_oe(i_link.restart_oe), .scl_out(i_link.scl_out), .sda_host_oe(i_link.sda_host_oe),
		.presence_n(i_link.presence_n), .attention_oe(i_link.attention_oe), .sda_dev_oe(i_link.sda_dev_oe),
		.bus_select_n(i_link.bus_select_n), .module_restart_n(i_link.module_restart_n),
		.attention_n(i_link.attention_n));
	initial begin
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			stop_test();
		end
	end
	task automatic stop_test;
		$display("tests %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wt(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask : wt
	// bounded so a dead handshake ends in a mismatch, not a hang
	task automatic wfor(ref logic s, output int c);
		for (c = 0; c < 60 && s !== 1'b1; c++) begin
			@(posedge mclk);
			#1;
		end
	endtask : wfor
	task automatic wr(input logic h, input logic [1:0] ad, input logic [7:0] d);
		@(posedge mclk);
		a <= ad;
		wd <= d;
		h_wr <= h;
		d_wr <= ~h;
		@(posedge mclk);
		h_wr <= 1'b0;
		d_wr <= 1'b0;
	endtask : wr
	task automatic rc(input logic h, input logic [1:0] ad, input logic [7:0] exp);
		@(posedge mclk);
		a <= ad;
		h_rd <= h;
		d_rd <= ~h;
		@(posedge mclk);
		h_rd <= 1'b0;
		d_rd <= 1'b0;
		#1;
		chk(h ? h_q : d_q, exp);
	endtask : rc
	task automatic clr;
		wr(1'b0, `MSC_DEV_STATUS, 8'h07);
		wr(1'b1, `MSC_HOST_STATUS, 8'h07);
		wt(6);
	endtask : clr
	task automatic t_powerup;
		wfor(d_irq, n);
		chk({7'h0, i_link.attention_n}, 8'h00);
		chk({7'h0, dnr}, 8'h00);
		rc(1'b0, `MSC_DEV_STATUS, 8'h01);
		wt(8);
		chk({7'h0, h_irq}, 8'h01);
		clr();
		chk({7'h0, i_link.attention_n}, 8'h01);
		rc(1'b1, `MSC_HOST_STATUS, 8'h00);
		$display("power-up done");
	endtask : t_powerup
	task automatic t_select;
		@(posedge mclk);
		drv <= 1'b1;
		wt(10);
		chk({6'h0, sel, i_link.sda}, 8'h01);
		// host traffic while deselected must stay invisible inside
		@(posedge mclk);
		h_scl <= 1'b0;
		h_sda <= 1'b1;
		wt(10);
		chk({5'h0, tscl, tws, i_link.sda}, 8'h06);
		@(posedge mclk);
		h_sda <= 1'b0;
		wr(1'b1, `MSC_HOST_CTRL, 8'h01);
		wt(12);
		chk({4'h0, tscl, tws, sel, i_link.sda}, 8'h02);
		chk({7'h0, h_sdi}, 8'h00);
		wr(1'b1, `MSC_HOST_CTRL, 8'h00);
		wt(10);
		chk({6'h0, sel, i_link.sda}, 8'h01);
		@(posedge mclk);
		drv <= 1'b0;
		h_scl <= 1'b1;
		$display("select done");
	endtask : t_select
	task automatic t_lowpower;
		wr(1'b1, `MSC_HOST_CTRL, 8'h02);
		wt(10);
		chk({7'h0, lp}, 8'h01);
		rc(1'b0, `MSC_DEV_STATE, 8'h0a);
		wr(1'b1, `MSC_HOST_CTRL, 8'h00);
		wt(10);
		chk({7'h0, lp}, 8'h00);
		$display("low-power done");
	endtask : t_lowpower
	task automatic t_fault;
		@(posedge mclk);
		flt <= 1'b1;
		crit <= 1'b1;
		@(posedge mclk);
		flt <= 1'b0;
		crit <= 1'b0;
		wt(6);
		chk({7'h0, i_link.attention_n}, 8'h00);
		rc(1'b0, `MSC_DEV_STATUS, 8'h06);
		wt(4);
		chk({7'h0, h_irq}, 8'h01);
		clr();
		chk({7'h0, i_link.attention_n}, 8'h01);
		$display("fault done");
	endtask : t_fault
	task automatic t_restart;
		wr(1'b0, `MSC_DEV_MASK, 8'h02);
		wr(1'b1, `MSC_HOST_CTRL, 8'h04);
		wfor(rest, n);
		chk({6'h0, rest, dnr}, 8'h03);
		chk({7'h0, i_link.attention_n}, 8'h01);
		wfor(d_irq, n);
		chk({7'h0, n >= 20 && n <= 25}, 8'h01);
		chk({7'h0, dnr}, 8'h00);
		rc(1'b1, `MSC_HOST_LINE, 8'h09);
		rc(1'b0, `MSC_DEV_MASK, 8'h07);
		wt(6);
		rc(1'b1, `MSC_HOST_STATUS, 8'h05);
		clr();
		$display("restart done");
	endtask : t_restart
	task automatic t_presence;
		ins <= 1'b0;
		wt(8);
		chk({7'h0, i_link.presence_seen_n}, 8'h01);
		ins <= 1'b1;
		wt(8);
		chk({7'h0, i_link.presence_seen_n}, 8'h00);
		rc(1'b1, `MSC_HOST_STATUS, 8'h02);
		clr();
		$display("presence done");
	endtask : t_presence
	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		t_powerup();
		t_select();
		t_lowpower();
		t_fault();
		t_restart();
		t_presence();
		stop_test();
	end
endmodule : module_sideband_control_tb

//--- testbench/msc_sideband_props.sv
`timescale 1ns/10ps
module msc_sideband_props (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic module_inserted,
	input wire logic sel_oe,
	input wire logic restart_oe,
	input wire logic scl_out,
	input wire logic sda_host_oe,
	input wire logic presence_n,
	input wire logic attention_oe,
	input wire logic sda_dev_oe,
	input wire logic bus_select_n,
	input wire logic module_restart_n,
	input wire logic attention_n
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_presence_tied: assert property (!presence_n) else $error("presence not low");
	a_attn_pull: assert property (attention_oe && module_inserted |-> !attention_n) else $error("attn not low");
	a_deselect_quiet: assert property (bus_select_n [*8] |-> !sda_dev_oe) else $error("sda driven");
	// init count only starts at release, so nothing may rise early
	a_powerup_attn: assert property ($rose(rst_n) |-> !attention_oe [*8] ##[10:30] attention_oe)
		else $error("no power-up attention");
	a_init_quiet: assert property ($rose(module_restart_n) |-> !attention_oe [*8]) else $error("early attn");
	a_attn_hold: assert property ($rose(attention_oe) |=> attention_oe) else $error("attn glitch");
	a_restart_hold: assert property ($rose(restart_oe) |-> restart_oe [*8] ##1 restart_oe [*8] ##1 !restart_oe)
		else $error("restart pulse length");
	a_host_idle: assert property ($rose(rst_n) |-> !sel_oe && !restart_oe && scl_out && !sda_host_oe)
		else $error("host not idle");
endmodule : msc_sideband_props
